// *** ssi_cfg.svh ***
`ifndef SSI_CFG_SVH
`define SSI_CFG_SVH

// ==========================================================
// Register map (byte addresses)
`define SSI_ADDR_W 12
`define SSI_ADDR_CTRL 12'h000
`define SSI_ADDR_STAT 12'h004

// ==========================================================
// Control word fields
`define SSI_CTRL_MODE 0
`define SSI_CTRL_STRAP_LSB 1
`define SSI_CTRL_RST 32'h00000000

// ==========================================================
// Status word fields
`define SSI_STAT_STRAP_LSB 0
`define SSI_STAT_METHOD_LSB 2
`define SSI_STAT_STRAP_EN 4
`define SSI_STAT_VALID 5
`define SSI_STAT_PWR 6
`define SSI_STAT_IND 7
`define SSI_STAT_NONREM_LSB 8

// ==========================================================
// Configuration method codes {bit1, bit0}
`define SSI_METHOD_DEF_SELF 2'b00
`define SSI_METHOD_SERIAL 2'b01
`define SSI_METHOD_DEF_BUS 2'b10
`define SSI_METHOD_EEPROM 2'b11

// ==========================================================
// Fixed-port decode, port 4 in the top bit
`define SSI_NONREM_00 4'h0
`define SSI_NONREM_01 4'h1
`define SSI_NONREM_10 4'h3
`define SSI_NONREM_11 4'h7

// ==========================================================
// Edges after reset release before pins are trusted
`define SSI_SETTLE_CYC 2'h2

`endif

// *** ssi_pkg.sv ***
package ssi_pkg;

  typedef enum logic [0:0] {
    ST_SETTLE,
    ST_RUN
  } ssi_state_t;

  typedef struct packed {
    logic [3:0] sy1;
    logic [3:0] sy2;
    ssi_state_t st;
    logic [1:0] cnt;
    logic [1:0] method;
    logic strap_en;
    logic [1:0] strap;
    logic valid;
    logic mode;
    logic [1:0] sw_strap;
    logic ind;
    logic oe;
    logic pwr;
    logic [3:0] nonrem;
    logic [31:0] rdata;
  } ssi_regs_t;

endpackage

// *** ssi_top.sv ***
`timescale 1ns/10ps
`include "ssi_cfg.svh"

module ssi_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SSI_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Multifunction pin
  input wire logic active_state_indicator_in,
  output logic active_state_indicator_out,
  output logic active_state_indicator_oe,
  // Other strap pins
  input wire logic fixed_port_strap_bit1,
  input wire logic config_method_bit0,
  input wire logic config_method_bit1,
  // Hub core state
  input wire logic hub_configured,
  input wire logic hub_suspended,
  // Results
  output logic self_power_sense,
  output logic [3:0] fixed_port_nonremovable,
  output logic [1:0] config_method,
  output logic strap_valid
);

  ssi_pkg::ssi_regs_t s_q;
  ssi_pkg::ssi_regs_t s_d;

  logic [1:0] eff_strap;
  logic hub_active;
  logic addr_ok;
  logic acc_wr;

  // ==========================================================
  // Effective values
  // Loaded value replaces the straps in serial and EEPROM methods
  assign eff_strap = s_q.strap_en ? s_q.strap : s_q.sw_strap;
  // Configured and not suspended counts as active
  assign hub_active = hub_configured & ~hub_suspended;
  assign addr_ok = (paddr == `SSI_ADDR_CTRL) ||
                   (paddr == `SSI_ADDR_STAT);
  assign acc_wr = psel & penable & pwrite;

  // ==========================================================
  // APB handshake
  // Zero wait states: every access completes in its first cycle
  assign pready = 1'b1;
  // Unmapped offsets answer with an error; writes to them are dropped
  assign pslverr = psel & penable & ~addr_ok;
  assign prdata = s_q.rdata;

  // ==========================================================
  // Outputs
  assign active_state_indicator_out = s_q.ind;
  assign active_state_indicator_oe = s_q.oe;
  assign self_power_sense = s_q.pwr;
  assign fixed_port_nonremovable = s_q.nonrem;
  assign config_method = s_q.method;
  assign strap_valid = s_q.valid;

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.sy1 = {config_method_bit1, config_method_bit0,
               fixed_port_strap_bit1, active_state_indicator_in};
    s_d.sy2 = s_q.sy1;
    case (s_q.st)
      ssi_pkg::ST_SETTLE: begin
        // Synchronisers hold reset constants until two edges pass
        if (s_q.cnt == `SSI_SETTLE_CYC) begin
          s_d.st = ssi_pkg::ST_RUN;
          s_d.method = s_q.sy2[3:2];
          s_d.strap_en = ~s_q.sy2[2];
          if (~s_q.sy2[2]) begin
            s_d.strap = s_q.sy2[1:0];
          end
          s_d.valid = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt + 2'h1;
        end
      end
      ssi_pkg::ST_RUN: begin
        // Captured values stand until the next reset
        s_d.st = ssi_pkg::ST_RUN;
      end
      default: begin
        // Unreachable with two states; recover into a fresh capture
        s_d.st = ssi_pkg::ST_SETTLE;
      end
    endcase

    // Bit 0 of the strap sets the indicator polarity
    s_d.ind = hub_active ^ eff_strap[0];
    // Driver stays off in reset, settle and sense mode
    s_d.oe = s_q.valid & ~s_q.mode;
    // Sense reads the synchronised pin, never the raw level
    s_d.pwr = s_q.valid & s_q.mode & s_q.sy2[0];

    // Port map stays clear until the straps are trusted
    if (!s_q.valid) begin
      s_d.nonrem = 4'h0;
    end else begin
      case (eff_strap)
        2'b00: s_d.nonrem = `SSI_NONREM_00;
        2'b01: s_d.nonrem = `SSI_NONREM_01;
        2'b10: s_d.nonrem = `SSI_NONREM_10;
        default: s_d.nonrem = `SSI_NONREM_11;
      endcase
    end

    // Mode and software strap are the only writable fields
    if (acc_wr && paddr == `SSI_ADDR_CTRL) begin
      s_d.mode = pwdata[`SSI_CTRL_MODE];
      s_d.sw_strap = pwdata[`SSI_CTRL_STRAP_LSB+:2];
    end

    // Read data is fetched in setup so it comes from a flop
    if (psel && !penable) begin
      s_d.rdata = 32'h00000000;
      if (paddr == `SSI_ADDR_CTRL) begin
        s_d.rdata[`SSI_CTRL_MODE] = s_q.mode;
        s_d.rdata[`SSI_CTRL_STRAP_LSB+:2] = s_q.sw_strap;
      end else if (paddr == `SSI_ADDR_STAT) begin
        s_d.rdata[`SSI_STAT_STRAP_LSB+:2] = eff_strap;
        s_d.rdata[`SSI_STAT_METHOD_LSB+:2] = s_q.method;
        s_d.rdata[`SSI_STAT_STRAP_EN] = s_q.strap_en;
        s_d.rdata[`SSI_STAT_VALID] = s_q.valid;
        s_d.rdata[`SSI_STAT_PWR] = s_q.pwr;
        s_d.rdata[`SSI_STAT_IND] = s_q.ind;
        s_d.rdata[`SSI_STAT_NONREM_LSB+:4] = s_q.nonrem;
      end
    end
  end

  // ==========================================================
  // State register
  // One flop bank for all state keeps the reset value uniform
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // All checks pause while reset is asserted

  a_ind_active_level: assert property (
    s_q.valid && !s_q.mode |=>
      active_state_indicator_out ==
      ($past(hub_active) ^ $past(eff_strap[0])))
    else $error("indicator does not follow hub state");

  a_power_sense_level: assert property (
    s_q.valid && s_q.mode |=> self_power_sense == $past(s_q.sy2[0]))
    else $error("self power sense wrong");

  a_strap_capture_value: assert property (
    s_q.st == ssi_pkg::ST_SETTLE && s_q.cnt == `SSI_SETTLE_CYC &&
    !s_q.sy2[2] |=> s_q.strap == $past(s_q.sy2[1:0]))
    else $error("strap not captured");

  a_strap_decode_map: assert property (
    s_q.valid ##1 $stable(eff_strap) |->
      fixed_port_nonremovable[3] == 1'b0 &&
      fixed_port_nonremovable[0] == (eff_strap != 2'b00) &&
      fixed_port_nonremovable[1] == eff_strap[1] &&
      fixed_port_nonremovable[2] == (eff_strap == 2'b11))
    else $error("fixed port decode wrong");

  a_ind_idle_polarity: assert property (
    s_q.valid && !s_q.mode && !hub_active |=>
      active_state_indicator_out == $past(eff_strap[0]))
    else $error("indicator idle level wrong");

  a_method_held_stable: assert property (
    s_q.valid ##1 s_q.valid |-> $stable(config_method))
    else $error("method changed after capture");

  a_strap_loaded_wins: assert property (
    s_q.valid && config_method[0] |->
      eff_strap == s_q.sw_strap && s_q.strap == 2'b00)
    else $error("strap used in loaded method");

  a_oe_after_capture: assert property (
    !s_q.valid |-> !active_state_indicator_oe [*2])
    else $error("pin driven before capture");

  // ==========================================================
  // Capture and hold after reset release
  // Release is seen as a fall of the sampled reset

  a_valid_after_release: assert property (
    $fell(rst) |-> !strap_valid [*3] ##1 strap_valid)
    else $error("capture not on third edge after release");

  a_oe_quiet_release: assert property (
    $fell(rst) |-> !active_state_indicator_oe [*4])
    else $error("pin driven during settle");

  a_valid_sticky: assert property (
    strap_valid |=> strap_valid)
    else $error("capture lost before reset");

  a_strap_held_stable: assert property (
    s_q.valid ##1 s_q.valid |-> $stable(s_q.strap))
    else $error("strap changed after capture");

  a_method_capture_value: assert property (
    s_q.st == ssi_pkg::ST_SETTLE && s_q.cnt == `SSI_SETTLE_CYC |=>
      config_method == $past(s_q.sy2[3:2]) && strap_valid)
    else $error("method not latched at capture");

  a_method_zero_settle: assert property (
    !s_q.valid |-> config_method == 2'h0)
    else $error("method shown before capture");

  a_strap_skip_loaded: assert property (
    s_q.st == ssi_pkg::ST_SETTLE && s_q.cnt == `SSI_SETTLE_CYC &&
    s_q.sy2[2] |=> s_q.strap == 2'h0 && !s_q.strap_en)
    else $error("strap taken in loaded method");

  a_strap_en_method: assert property (
    s_q.valid |-> s_q.strap_en == !config_method[0])
    else $error("strap enable disagrees with method");

  // ==========================================================
  // Outputs against mode and hub state
  // Expected levels are rebuilt from the rules, not the next state

  a_nonrem_before_valid: assert property (
    !s_q.valid |=> fixed_port_nonremovable == 4'h0)
    else $error("port map set before capture");

  a_decode_one_port: assert property (
    s_q.valid ##1 ($stable(eff_strap) && eff_strap == 2'h1) |->
      fixed_port_nonremovable == `SSI_NONREM_01)
    else $error("one fixed port decode wrong");

  a_decode_two_ports: assert property (
    s_q.valid ##1 ($stable(eff_strap) && eff_strap == 2'h2) |->
      fixed_port_nonremovable == `SSI_NONREM_10)
    else $error("two fixed ports decode wrong");

  a_decode_three_ports: assert property (
    s_q.valid ##1 ($stable(eff_strap) && eff_strap == 2'h3) |->
      fixed_port_nonremovable == `SSI_NONREM_11)
    else $error("three fixed ports decode wrong");

  a_ind_asserted_active: assert property (
    s_q.valid |=>
      (active_state_indicator_out ^ $past(eff_strap[0])) ==
      $past(hub_active))
    else $error("indicator asserted while hub idle");

  a_ind_negated_suspend: assert property (
    s_q.valid && hub_configured && hub_suspended |=>
      active_state_indicator_out == $past(eff_strap[0]))
    else $error("indicator asserted in suspend");

  a_oe_follows_mode: assert property (
    s_q.valid |=> active_state_indicator_oe == !$past(s_q.mode))
    else $error("driver enable disagrees with mode");

  a_oe_off_sense: assert property (
    s_q.mode |=> !active_state_indicator_oe)
    else $error("pin driven in sense mode");

  a_pwr_off_drive_mode: assert property (
    !s_q.mode || !s_q.valid |=> !self_power_sense)
    else $error("self power reported outside sense mode");

  a_ctrl_mode_write: assert property (
    psel && penable && pwrite && paddr == `SSI_ADDR_CTRL |=>
      s_q.mode == $past(pwdata[`SSI_CTRL_MODE]))
    else $error("mode write lost");

  // ==========================================================
  // Coverage of the main scenarios
  c_indicator_driven: cover property (
    s_q.valid && active_state_indicator_oe && hub_active);
  c_sense_mode_high: cover property (
    s_q.valid && s_q.mode ##1 self_power_sense);
  c_loaded_method: cover property (
    s_q.valid && config_method == `SSI_METHOD_EEPROM);
  c_active_low_driven: cover property (
    s_q.valid && eff_strap[0] && active_state_indicator_oe);
  c_three_ports_fixed: cover property (
    s_q.valid && fixed_port_nonremovable == `SSI_NONREM_11);

endmodule

// *** ssi_board.sv ***
`timescale 1ns/10ps
// ==========================================================
// Board at the multifunction pin: strap resistor or supply
module ssi_board (
  // Device side of the pin
  input wire logic pin_oe,
  input wire logic pin_out,
  // Strap level during reset, supply level in sense mode
  input wire logic board_lvl,
  output logic pin_lvl
);
  // Device drive wins; otherwise the board sets the level
  assign pin_lvl = pin_oe ? pin_out : board_lvl;
endmodule

// *** tb_top.sv ***
`timescale 1ns/10ps
`include "ssi_cfg.svh"
module tb_top;
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, oe, out, pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic lvl, b1, m0, m1, cfg, sus, sense, valid, e, en, p;
  logic [3:0] nonrem;
  logic [1:0] meth, m, s, sw, eff;
  int errors, comparisons;
  ssi_top DUT (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .active_state_indicator_in(pin), .active_state_indicator_out(out),
    .active_state_indicator_oe(oe), .fixed_port_strap_bit1(b1),
    .config_method_bit0(m0), .config_method_bit1(m1),
    .hub_configured(cfg), .hub_suspended(sus), .self_power_sense(sense),
    .fixed_port_nonremovable(nonrem), .config_method(meth),
    .strap_valid(valid));
  ssi_board board (.pin_oe(oe), .pin_out(out), .board_lvl(lvl),
    .pin_lvl(pin));
  // ==========================================================
  // Clock, checks, bus cycles
  initial begin
    sys_clk = 0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  function automatic logic [3:0] dec(input logic [1:0] v);
    return v == 2'h0 ? 4'h0 : v == 2'h1 ? 4'h1 : v == 2'h2 ? 4'h3 : 4'h7;
  endfunction
  // ==========================================================
  // Watchdog; the full run needs about 16 x 52 cycles
  initial begin
    #100000;
    errors++;
    final_report();
  end
  // ==========================================================
  // Every method code against every strap value
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {rst, lvl, b1, m0, m1, cfg, sus} = 7'h40;
    void'($urandom(61));
    for (int i = 0; i < 16; i++) begin
      {m, s} = 4'(i);
      sw = 2'($urandom);
      @(posedge sys_clk);
      rst <= 1;
      {b1, lvl} <= s;
      {m1, m0} <= m;
      repeat (20) @(posedge sys_clk);
      chk(oe, 0);
      rst <= 0;
      repeat (6) @(posedge sys_clk);
      {b1, lvl} <= ~s;
      apb(1, `SSI_ADDR_CTRL, 32'({sw, 1'b0}));
      cfg <= 1'($urandom);
      sus <= 1'($urandom);
      repeat (4) @(posedge sys_clk);
      en = !m[0];
      eff = en ? s : sw;
      chk(meth, m);
      chk(valid, 1);
      chk(nonrem, dec(eff));
      chk(oe, 1);
      chk(out, (cfg & !sus) ^ eff[0]);
      apb(0, `SSI_ADDR_STAT, 0);
      chk(r[5:0], {1'b1, en, m, eff});
      chk(r[11:6], {dec(eff), (cfg & !sus) ^ eff[0], 1'b0});
      chk(e, 0);
      p = 1'($urandom);
      apb(1, `SSI_ADDR_CTRL, 32'({sw, 1'b1}));
      lvl <= p;
      repeat (6) @(posedge sys_clk);
      chk(oe, 0);
      chk(sense, p);
      apb(0, `SSI_ADDR_CTRL, 0);
      chk(r, 32'({sw, 1'b1}));
      apb(0, 12'h008, 0);
      chk(e, 1);
      chk(r, 32'h00000000);
    end
    final_report();
  end
endmodule
